// ### mxe_pkg.sv
package mxe_pkg;

    // ****************************************
    // Widths and sizes
    // ****************************************
    localparam int DATA_W = 8;
    localparam int DADDR_W = 7;
    localparam int BIT_W = 3;
    localparam int PWORD_W = 14;
    localparam int PADDR_W = 10;
    localparam int TPTR_W = 8;
    localparam int PAGE_W = PADDR_W - TPTR_W;
    localparam int THIGH_W = PWORD_W - DATA_W;
    localparam int NIB_W = 4;

    // ****************************************
    // Constant values
    // ****************************************
    localparam logic [DATA_W-1:0] BYTE_ONES = 8'hff;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
    localparam logic [PAGE_W-1:0] LAST_PAGE = 2'h3;

    // ****************************************
    // Flag register layout
    // ****************************************
    localparam int FLAG_W = 4;
    localparam int FLAG_C = 0;
    localparam int FLAG_AC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 4'h0;

    // ****************************************
    // Register map, byte addresses
    // ****************************************
    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] REG_WORK = 8'h00;
    localparam logic [AXI_AW-1:0] REG_FLAGS = 8'h04;
    localparam logic [AXI_AW-1:0] REG_TPTR = 8'h08;
    localparam logic [AXI_AW-1:0] REG_THIGH = 8'h0c;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h10;
    localparam int STATUS_DUMMY = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // Operations
    // ****************************************
    typedef enum logic [3:0] {
        OP_SET_BYTE, OP_SET_BIT, OP_INC_SKIP, OP_INC_WORK_SKIP,
        OP_BIT_HIGH_SKIP, OP_BIT_LOW_SKIP, OP_SUB_WORK, OP_SUB_MEM,
        OP_SUB_IMM, OP_SWAP, OP_SWAP_WORK, OP_ZERO_SKIP,
        OP_LOAD_SKIP, OP_TBL_CUR, OP_TBL_LAST, OP_XOR_WORK
    } mxe_op_e;

    typedef struct packed {
        mxe_op_e op;
        logic [DADDR_W-1:0] addr;
        logic [BIT_W-1:0] bit_sel;
        logic [DATA_W-1:0] imm;
    } mxe_ins_s;

endpackage

// ### mxe_exec.sv
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module mxe_exec #(
    parameter int DM_DEPTH = 64
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Instruction issue
    input wire logic ins_valid,
    output logic ins_ready,
    input wire mxe_pkg::mxe_ins_s ins,
    input wire logic [mxe_pkg::PAGE_W-1:0] cur_page,
    output logic skip_pulse,
    // Program memory read
    output logic [mxe_pkg::PADDR_W-1:0] pm_addr,
    input wire logic [mxe_pkg::PWORD_W-1:0] pm_rdata,
    // AXI4-Lite write
    input wire logic [mxe_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [mxe_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ****************************************
    // State
    // ****************************************
    typedef enum logic {EX_RUN, EX_DUMMY} mxe_state_e;

    mxe_state_e state;
    logic [mxe_pkg::DATA_W-1:0] dmem [DM_DEPTH];
    logic [mxe_pkg::DATA_W-1:0] work_register;
    logic [mxe_pkg::FLAG_W-1:0] flags;
    logic [mxe_pkg::TPTR_W-1:0] table_pointer;
    logic [mxe_pkg::THIGH_W-1:0] table_high_byte;

    logic exec;
    logic addr_ok;
    logic [mxe_pkg::DATA_W-1:0] mem_val;
    logic [mxe_pkg::DATA_W-1:0] inc_val;
    logic [mxe_pkg::DATA_W-1:0] swap_val;
    logic [mxe_pkg::DATA_W-1:0] sub_b;
    logic [mxe_pkg::DATA_W:0] sub_sum;
    logic [mxe_pkg::NIB_W:0] sub_half;
    logic [mxe_pkg::DATA_W-1:0] sub_res;
    logic sel_bit;
    logic [mxe_pkg::DATA_W-1:0] next_mem;
    logic mem_we;
    logic [mxe_pkg::DATA_W-1:0] next_work;
    logic work_we;
    logic [mxe_pkg::FLAG_W-1:0] next_flags;
    logic flags_we;
    logic tbl_we;
    logic next_skip;

    // ****************************************
    // Datapath
    // ****************************************
    assign ins_ready = (state == EX_RUN);
    assign exec = ins_valid && ins_ready;
    assign addr_ok = (32'(ins.addr) < DM_DEPTH);
    assign mem_val = addr_ok ? dmem[ins.addr[$clog2(DM_DEPTH)-1:0]] : mxe_pkg::BYTE_ZERO;
    assign inc_val = mem_val + mxe_pkg::BYTE_ONE;
    assign swap_val = {mem_val[mxe_pkg::NIB_W-1:0], mem_val[mxe_pkg::DATA_W-1:mxe_pkg::NIB_W]};
    assign sel_bit = mem_val[ins.bit_sel];
    assign sub_b = (ins.op == mxe_pkg::OP_SUB_IMM) ? ins.imm : mem_val;
    assign sub_sum = {1'b0, work_register} + {1'b0, ~sub_b} + 9'h001;
    assign sub_half = {1'b0, work_register[mxe_pkg::NIB_W-1:0]} + {1'b0, ~sub_b[mxe_pkg::NIB_W-1:0]} + 5'h01;
    assign sub_res = sub_sum[mxe_pkg::DATA_W-1:0];
    assign pm_addr = (ins.op == mxe_pkg::OP_TBL_LAST) ? {mxe_pkg::LAST_PAGE, table_pointer}
                                                      : {cur_page, table_pointer};

    always_comb begin
        next_mem = mem_val;
        mem_we = 1'b0;
        next_work = work_register;
        work_we = 1'b0;
        next_flags = flags;
        flags_we = 1'b0;
        tbl_we = 1'b0;
        next_skip = 1'b0;
        unique case (ins.op)
            mxe_pkg::OP_SET_BYTE: begin
                next_mem = mxe_pkg::BYTE_ONES;
                mem_we = 1'b1;
            end
            mxe_pkg::OP_SET_BIT: begin
                next_mem[ins.bit_sel] = 1'b1;
                mem_we = 1'b1;
            end
            mxe_pkg::OP_INC_SKIP: begin
                next_mem = inc_val;
                mem_we = 1'b1;
                next_skip = (inc_val == mxe_pkg::BYTE_ZERO);
            end
            mxe_pkg::OP_INC_WORK_SKIP: begin
                next_work = inc_val;
                work_we = 1'b1;
                next_skip = (inc_val == mxe_pkg::BYTE_ZERO);
            end
            mxe_pkg::OP_BIT_HIGH_SKIP: begin
                next_skip = sel_bit;
            end
            mxe_pkg::OP_BIT_LOW_SKIP: begin
                next_skip = !sel_bit;
            end
            mxe_pkg::OP_SUB_WORK, mxe_pkg::OP_SUB_IMM, mxe_pkg::OP_SUB_MEM: begin
                if (ins.op == mxe_pkg::OP_SUB_MEM) begin
                    next_mem = sub_res;
                    mem_we = 1'b1;
                end else begin
                    next_work = sub_res;
                    work_we = 1'b1;
                end
                flags_we = 1'b1;
                next_flags[mxe_pkg::FLAG_C] = sub_sum[mxe_pkg::DATA_W];
                next_flags[mxe_pkg::FLAG_AC] = sub_half[mxe_pkg::NIB_W];
                next_flags[mxe_pkg::FLAG_Z] = (sub_res == mxe_pkg::BYTE_ZERO);
                next_flags[mxe_pkg::FLAG_OV] = (work_register[mxe_pkg::DATA_W-1] != sub_b[mxe_pkg::DATA_W-1])
                    && (sub_res[mxe_pkg::DATA_W-1] != work_register[mxe_pkg::DATA_W-1]);
            end
            mxe_pkg::OP_SWAP: begin
                next_mem = swap_val;
                mem_we = 1'b1;
            end
            mxe_pkg::OP_SWAP_WORK: begin
                next_work = swap_val;
                work_we = 1'b1;
            end
            mxe_pkg::OP_ZERO_SKIP: begin
                next_skip = (mem_val == mxe_pkg::BYTE_ZERO);
            end
            mxe_pkg::OP_LOAD_SKIP: begin
                next_work = mem_val;
                work_we = 1'b1;
                next_skip = (mem_val == mxe_pkg::BYTE_ZERO);
            end
            mxe_pkg::OP_TBL_CUR, mxe_pkg::OP_TBL_LAST: begin
                next_mem = pm_rdata[mxe_pkg::DATA_W-1:0];
                mem_we = 1'b1;
                tbl_we = 1'b1;
            end
            mxe_pkg::OP_XOR_WORK: begin
                next_work = work_register ^ mem_val;
                work_we = 1'b1;
                flags_we = 1'b1;
                next_flags[mxe_pkg::FLAG_Z] = ((work_register ^ mem_val) == mxe_pkg::BYTE_ZERO);
            end
        endcase
    end

    // ****************************************
    // Skip sequencing
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= EX_RUN;
            skip_pulse <= 1'b0;
        end else begin
            skip_pulse <= exec && next_skip;
            unique case (state)
                EX_RUN: state <= (exec && next_skip) ? EX_DUMMY : EX_RUN;
                EX_DUMMY: state <= EX_RUN;
            endcase
        end
    end

    // ****************************************
    // Data memory
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < DM_DEPTH; i++) begin
                dmem[i] <= mxe_pkg::BYTE_ZERO;
            end
        end else if (exec && mem_we && addr_ok) begin
            dmem[ins.addr[$clog2(DM_DEPTH)-1:0]] <= next_mem;
        end
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic aw_got;
    logic w_got;
    logic [mxe_pkg::AXI_AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic sw_we;
    logic [31:0] rd_val;
    logic rd_ok;

    assign s_axi_awready = !aw_got && !s_axi_bvalid;
    assign s_axi_wready = !w_got && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign sw_we = aw_got && w_got && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= mxe_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (sw_we) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == mxe_pkg::REG_WORK || aw_addr == mxe_pkg::REG_FLAGS
                    || aw_addr == mxe_pkg::REG_TPTR) ? mxe_pkg::RESP_OKAY : mxe_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_ok = 1'b1;
        rd_val = '0;
        unique case (s_axi_araddr)
            mxe_pkg::REG_WORK: rd_val[mxe_pkg::DATA_W-1:0] = work_register;
            mxe_pkg::REG_FLAGS: rd_val[mxe_pkg::FLAG_W-1:0] = flags;
            mxe_pkg::REG_TPTR: rd_val[mxe_pkg::TPTR_W-1:0] = table_pointer;
            mxe_pkg::REG_THIGH: rd_val[mxe_pkg::THIGH_W-1:0] = table_high_byte;
            mxe_pkg::REG_STATUS: rd_val[mxe_pkg::STATUS_DUMMY] = (state == EX_DUMMY);
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= mxe_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? mxe_pkg::RESP_OKAY : mxe_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // Core registers, instruction before software
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            work_register <= mxe_pkg::BYTE_ZERO;
        end else if (exec && work_we) begin
            work_register <= next_work;
        end else if (sw_we && aw_addr == mxe_pkg::REG_WORK && w_strb[0]) begin
            work_register <= w_data[mxe_pkg::DATA_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= mxe_pkg::FLAGS_RST;
        end else if (exec && flags_we) begin
            flags <= next_flags;
        end else if (sw_we && aw_addr == mxe_pkg::REG_FLAGS && w_strb[0]) begin
            flags <= w_data[mxe_pkg::FLAG_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            table_pointer <= '0;
        end else if (sw_we && aw_addr == mxe_pkg::REG_TPTR && w_strb[0]) begin
            table_pointer <= w_data[mxe_pkg::TPTR_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            table_high_byte <= '0;
        end else if (exec && tbl_we) begin
            table_high_byte <= pm_rdata[mxe_pkg::PWORD_W-1:mxe_pkg::DATA_W];
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_SET_ONES: assert property (exec && ins.op == mxe_pkg::OP_SET_BYTE && addr_ok
        |=> dmem[$past(ins.addr[$clog2(DM_DEPTH)-1:0])] == mxe_pkg::BYTE_ONES && $stable(flags))
        else $error("Set byte did not give all ones");

    AST_SKIP_TWO: assert property (skip_pulse |-> !ins_ready ##1 ins_ready)
        else $error("Skip did not take exactly one dummy cycle");

    AST_NO_SKIP_ONE: assert property (exec && !next_skip |=> ins_ready && !skip_pulse)
        else $error("Non-skipping instruction stalled");

    AST_SUB_WORK: assert property (exec && ins.op == mxe_pkg::OP_SUB_WORK
        |=> work_register == $past(work_register) - $past(mem_val))
        else $error("Subtract to work register wrong");

    AST_SUB_CARRY: assert property (exec && ins.op == mxe_pkg::OP_SUB_IMM
        |=> flags[mxe_pkg::FLAG_C] == ($past(work_register) >= $past(ins.imm)))
        else $error("Subtract carry not the no-borrow sense");

    AST_SWAP_WORK_KEEP: assert property (exec && ins.op == mxe_pkg::OP_SWAP_WORK && addr_ok
        |=> dmem[$past(ins.addr[$clog2(DM_DEPTH)-1:0])] == $past(mem_val) && work_register == $past(swap_val))
        else $error("Nibble exchange to work altered memory");

    AST_XOR_ZERO: assert property (exec && ins.op == mxe_pkg::OP_XOR_WORK && work_register == mem_val
        |=> flags[mxe_pkg::FLAG_Z] && work_register == mxe_pkg::BYTE_ZERO)
        else $error("Xor to work zero flag missing");

    AST_TBL_HIGH: assert property (exec && ins.op == mxe_pkg::OP_TBL_LAST
        |-> pm_addr[mxe_pkg::PADDR_W-1:mxe_pkg::TPTR_W] == mxe_pkg::LAST_PAGE
        ##1 table_high_byte == $past(pm_rdata[mxe_pkg::PWORD_W-1:mxe_pkg::DATA_W]))
        else $error("Final page table read wrong");

    AST_BIT_LOW: assert property (exec && ins.op == mxe_pkg::OP_BIT_LOW_SKIP
        |=> skip_pulse == !$past(sel_bit) && $stable(flags))
        else $error("Bit low skip decision wrong");

endmodule // mxe_exec

// ### mxe_pm_model.sv
`timescale 1ns/1ps
// ****************************************
// Program memory model
// ****************************************
module mxe_pm_model (
    // Program memory read
    input wire logic [mxe_pkg::PADDR_W-1:0] pm_addr,
    output logic [mxe_pkg::PWORD_W-1:0] pm_rdata
);
    // Word pattern ties both halves to the address and page, answered in the same cycle
    assign pm_rdata = {pm_addr[9:4], pm_addr[9:2]};
endmodule // mxe_pm_model

// ### tb_mxe_exec.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin errors++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module tb_mxe_exec;
    // ****************************************
    // Signals
    // ****************************************
    typedef struct packed {
        mxe_pkg::mxe_op_e op;
        logic [2:0] bsel;
        logic [7:0] w_in, m_in, w_ex, m_ex;
        logic [3:0] f_ex;
        logic sk;
    } mxe_row_s;
    logic aclk, aresetn, ins_valid, ins_ready, skip_pulse;
    mxe_pkg::mxe_ins_s ins;
    logic [1:0] cur_page, bresp, rresp, resp;
    logic [9:0] pm_addr;
    logic [13:0] pm_rdata;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    int errors, checks;
    mxe_row_s rows [25];
    mxe_row_s r;
    logic [6:0] a;
    logic [5:0] th;

    mxe_exec #(.DM_DEPTH(64)) i_mxe_exec (.aclk(aclk), .aresetn(aresetn), .ins_valid(ins_valid),
        .ins_ready(ins_ready), .ins(ins), .cur_page(cur_page), .skip_pulse(skip_pulse), .pm_addr(pm_addr),
        .pm_rdata(pm_rdata), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    mxe_pm_model i_mxe_pm_model (.pm_addr(pm_addr), .pm_rdata(pm_rdata));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic report_and_stop();
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic hang();
        errors++;
        $display("mismatch handshake exp %h got %h", 1'b1, 1'b0);
        report_and_stop();
    endtask

    task automatic axi_wr(input logic [7:0] ad, input logic [7:0] d, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= ad;
        wdata <= {24'h000000, d};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                rs = bresp;
                bready <= 1'b0;
                return;
            end
        end
        hang();
    endtask

    task automatic rdc(input string nm, input logic [7:0] ad, input logic [31:0] ex, input logic [1:0] er);
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
                `CHK(nm, ex, rd)
                `CHK("rresp", er, resp)
                return;
            end
        end
        hang();
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        axi_wr(ad, d, resp);
        `CHK("bresp", mxe_pkg::RESP_OKAY, resp)
    endtask

    task automatic issue(input mxe_pkg::mxe_op_e op, input logic [6:0] ad, input logic [2:0] b,
                         input logic [7:0] im, input logic sk);
        @(posedge aclk);
        ins <= '{op, ad, b, im};
        ins_valid <= 1'b1;
        for (int n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (ins_ready) begin
                ins_valid <= 1'b0;
                @(negedge aclk);
                `CHK("skip", sk, skip_pulse)
                `CHK("ready", !sk, ins_ready)
                return;
            end
        end
        hang();
    endtask

    task automatic reset_regs();
        for (int k = 0; k < 5; k++) begin
            rdc("reset", 8'(k * 4), 32'h00000000, mxe_pkg::RESP_OKAY);
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rows = '{
            '{mxe_pkg::OP_SET_BYTE, 3'h0, 8'h12, 8'h34, 8'h12, 8'hff, 4'ha, 1'h0},
            '{mxe_pkg::OP_SET_BIT, 3'h5, 8'h12, 8'h01, 8'h12, 8'h21, 4'ha, 1'h0},
            '{mxe_pkg::OP_SET_BIT, 3'h7, 8'h12, 8'h00, 8'h12, 8'h80, 4'ha, 1'h0},
            '{mxe_pkg::OP_INC_SKIP, 3'h0, 8'h12, 8'hff, 8'h12, 8'h00, 4'ha, 1'h1},
            '{mxe_pkg::OP_INC_SKIP, 3'h0, 8'h12, 8'h7f, 8'h12, 8'h80, 4'ha, 1'h0},
            '{mxe_pkg::OP_INC_WORK_SKIP, 3'h0, 8'h55, 8'hff, 8'h00, 8'hff, 4'ha, 1'h1},
            '{mxe_pkg::OP_INC_WORK_SKIP, 3'h0, 8'h55, 8'h10, 8'h11, 8'h10, 4'ha, 1'h0},
            '{mxe_pkg::OP_BIT_HIGH_SKIP, 3'h3, 8'h12, 8'h08, 8'h12, 8'h08, 4'ha, 1'h1},
            '{mxe_pkg::OP_BIT_HIGH_SKIP, 3'h3, 8'h12, 8'hf7, 8'h12, 8'hf7, 4'ha, 1'h0},
            '{mxe_pkg::OP_SUB_WORK, 3'h0, 8'h05, 8'h03, 8'h02, 8'h03, 4'h3, 1'h0},
            '{mxe_pkg::OP_SUB_WORK, 3'h0, 8'h80, 8'h01, 8'h7f, 8'h01, 4'h9, 1'h0},
            '{mxe_pkg::OP_SUB_MEM, 3'h0, 8'h03, 8'h05, 8'h03, 8'hfe, 4'h0, 1'h0},
            '{mxe_pkg::OP_SUB_MEM, 3'h0, 8'h42, 8'h42, 8'h42, 8'h00, 4'h7, 1'h0},
            '{mxe_pkg::OP_SUB_IMM, 3'h0, 8'h10, 8'h01, 8'h0f, 8'h01, 4'h1, 1'h0},
            '{mxe_pkg::OP_SWAP, 3'h0, 8'h12, 8'ha5, 8'h12, 8'h5a, 4'ha, 1'h0},
            '{mxe_pkg::OP_SWAP_WORK, 3'h0, 8'h00, 8'h3c, 8'hc3, 8'h3c, 4'ha, 1'h0},
            '{mxe_pkg::OP_ZERO_SKIP, 3'h0, 8'h12, 8'h00, 8'h12, 8'h00, 4'ha, 1'h1},
            '{mxe_pkg::OP_ZERO_SKIP, 3'h0, 8'h12, 8'h01, 8'h12, 8'h01, 4'ha, 1'h0},
            '{mxe_pkg::OP_LOAD_SKIP, 3'h0, 8'h77, 8'h00, 8'h00, 8'h00, 4'ha, 1'h1},
            '{mxe_pkg::OP_LOAD_SKIP, 3'h0, 8'h77, 8'h9b, 8'h9b, 8'h9b, 4'ha, 1'h0},
            '{mxe_pkg::OP_BIT_LOW_SKIP, 3'h0, 8'h12, 8'hfe, 8'h12, 8'hfe, 4'ha, 1'h1},
            '{mxe_pkg::OP_BIT_LOW_SKIP, 3'h0, 8'h12, 8'h01, 8'h12, 8'h01, 4'ha, 1'h0},
            '{mxe_pkg::OP_XOR_WORK, 3'h0, 8'hf0, 8'hf0, 8'h00, 8'hf0, 4'he, 1'h0},
            '{mxe_pkg::OP_TBL_CUR, 3'h0, 8'h12, 8'h00, 8'h12, 8'h67, 4'ha, 1'h0},
            '{mxe_pkg::OP_TBL_LAST, 3'h0, 8'h12, 8'h00, 8'h12, 8'he7, 4'ha, 1'h0}
        };
        {ins_valid, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        ins = '0;
        cur_page = 2'h1;
        {awaddr, araddr, wdata, wstrb} = '0;
        aresetn = 1'b0;
        th = 6'h00;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        reset_regs();
        wr(mxe_pkg::REG_TPTR, 8'h9c);
        for (int i = 0; i < 25; i++) begin
            r = rows[i];
            a = 7'(i + 1);
            wr(mxe_pkg::REG_WORK, r.m_in);
            issue(mxe_pkg::OP_SUB_MEM, a, 3'h0, 8'h00, 1'b0);
            wr(mxe_pkg::REG_WORK, r.w_in);
            wr(mxe_pkg::REG_FLAGS, 8'h0a);
            issue(r.op, a, r.bsel, r.m_in, r.sk);
            if (r.op == mxe_pkg::OP_TBL_CUR) th = 6'h19;
            if (r.op == mxe_pkg::OP_TBL_LAST) th = 6'h39;
            rdc("work", mxe_pkg::REG_WORK, {24'h000000, r.w_ex}, mxe_pkg::RESP_OKAY);
            rdc("flags", mxe_pkg::REG_FLAGS, {28'h0000000, r.f_ex}, mxe_pkg::RESP_OKAY);
            rdc("thigh", mxe_pkg::REG_THIGH, {26'h0000000, th}, mxe_pkg::RESP_OKAY);
            issue(mxe_pkg::OP_SWAP_WORK, a, 3'h0, 8'h00, 1'b0);
            rdc("mem", mxe_pkg::REG_WORK, {24'h000000, r.m_ex[3:0], r.m_ex[7:4]}, mxe_pkg::RESP_OKAY);
        end
        // Unmapped read and read-only write
        rdc("unmapped", 8'h20, 32'h00000000, mxe_pkg::RESP_SLVERR);
        axi_wr(mxe_pkg::REG_THIGH, 8'h00, resp);
        `CHK("ro bresp", mxe_pkg::RESP_SLVERR, resp)
        rdc("thigh", mxe_pkg::REG_THIGH, 32'h00000039, mxe_pkg::RESP_OKAY);
        // Byte beyond the data memory reads as zero
        issue(mxe_pkg::OP_SET_BYTE, 7'h50, 3'h0, 8'h00, 1'b0);
        issue(mxe_pkg::OP_SWAP_WORK, 7'h50, 3'h0, 8'h00, 1'b0);
        rdc("far byte", mxe_pkg::REG_WORK, 32'h00000000, mxe_pkg::RESP_OKAY);
        // Second reset in mid-run
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        reset_regs();
        issue(mxe_pkg::OP_SWAP_WORK, 7'h01, 3'h0, 8'h00, 1'b0);
        rdc("reset mem", mxe_pkg::REG_WORK, 32'h00000000, mxe_pkg::RESP_OKAY);
        report_and_stop();
    end
endmodule // tb_mxe_exec
